// ==== verilog/smsel_pkg.sv ====
// smsel_pkg: constants, types and helpers of the smart mode button selector
package smsel_pkg;

   // timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int CYC_PER_MS    = CLK_HZ / 1000;
   localparam int HOLD_MS       = 5000;                   // long hold, least time
   localparam int HOLD_CYC      = HOLD_MS * CYC_PER_MS;
   localparam int DEBOUNCE_MS   = 20;                     // contact bounce settle time
   localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * CYC_PER_MS;
   localparam int BLINK_MS      = 250;                    // half period of the flash
   localparam int BLINK_CYC     = BLINK_MS * CYC_PER_MS;

   // aging time of the address table, in seconds
   localparam int              AGING_W   = 10;
   localparam logic [9:0]      AGING_DEF = 10'h028;       // 40 s
   localparam logic [9:0]      AGING_MIN = 10'h00a;       // 10 s
   localparam logic [9:0]      AGING_MAX = 10'h339;       // 825 s

   // display characters
   localparam logic [7:0]      CHAR_S     = 8'h53;
   localparam logic [7:0]      CHAR_1     = 8'h31;
   localparam logic [7:0]      CHAR_BLANK = 8'h20;

   typedef enum logic [2:0] {
      ST_BOOT   = 3'h1,
      ST_IDLE   = 3'h2,
      ST_SELECT = 3'h4
   } smsel_state_t;

   typedef enum logic [3:0] {
      CH_KEEP     = 4'h1,
      CH_DEFAULTS = 4'h2,
      CH_PROFINET = 4'h4,
      CH_ENIP     = 4'h8
   } smsel_choice_t;

   typedef enum logic [2:0] {
      MODE_ETH      = 3'h1,
      MODE_PROFINET = 3'h2,
      MODE_ENIP     = 3'h4
   } smsel_mode_t;

   typedef struct packed {
      logic activity_indicator;
      logic speed_indicator;
      logic duplex_indicator;
   } smsel_led_t;

   typedef struct packed {
      logic [7:0] left;
      logic [7:0] right;
   } smsel_disp_t;

   localparam smsel_led_t LED_OFF = 3'h0;
   localparam smsel_led_t LED_ALL = 3'h7;

   function automatic smsel_led_t choice_led(input smsel_choice_t c);
      smsel_led_t l;
      l = LED_OFF;
      unique case (c)
         CH_KEEP:     l = 3'h1;
         CH_DEFAULTS: l = 3'h2;
         CH_PROFINET: l = 3'h3;
         CH_ENIP:     l = 3'h4;
      endcase
      return l;
   endfunction

   function automatic logic [7:0] choice_char(input smsel_choice_t c);
      logic [7:0] ch;
      ch = CHAR_1;
      unique case (c)
         CH_KEEP:     ch = CHAR_1;
         CH_DEFAULTS: ch = CHAR_1 + 8'h01;
         CH_PROFINET: ch = CHAR_1 + 8'h02;
         CH_ENIP:     ch = CHAR_1 + 8'h03;
      endcase
      return ch;
   endfunction

   function automatic smsel_choice_t choice_next(input smsel_choice_t c);
      smsel_choice_t n;
      n = CH_KEEP;
      unique case (c)
         CH_KEEP:     n = CH_DEFAULTS;
         CH_DEFAULTS: n = CH_PROFINET;
         CH_PROFINET: n = CH_ENIP;
         CH_ENIP:     n = CH_KEEP;
      endcase
      return n;
   endfunction

endpackage

// ==== verilog/smsel_press.sv ====
// smsel_press: debounce and brief/long classification of the mode button
`timescale 1ns/1ps
module smsel_press #(
   parameter int DEB_CYC  = smsel_pkg::DEBOUNCE_CYC,
   parameter int HOLD_CYC = smsel_pkg::HOLD_CYC
) (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic button_in,
   output logic      pressed_out,
   output logic      brief_out,
   output logic      long_out
);
   localparam int              DW       = $clog2(DEB_CYC + 1);
   localparam int              HW       = $clog2(HOLD_CYC + 1);
   localparam logic [DW-1:0]   DEB_LAST = DW'(DEB_CYC - 1);
   localparam logic [HW-1:0]   HOLD_LAST = HW'(HOLD_CYC - 1);

   logic          db_r;
   logic          db_prev_r;
   logic [DW-1:0] deb_cnt_r;
   logic [HW-1:0] hold_r;
   logic          long_done_r;
   logic          brief_r;
   logic          long_r;

   // a level must stay put for the whole settle time before it is believed
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         db_r      <= 1'b0;
         deb_cnt_r <= '0;
      end
      else if (button_in == db_r)
         deb_cnt_r <= '0;
      else if (deb_cnt_r == DEB_LAST)
      begin
         db_r      <= button_in;
         deb_cnt_r <= '0;
      end
      else
         deb_cnt_r <= deb_cnt_r + 1'b1;
   end

   // hold timer saturates so a very long hold fires only once
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         hold_r <= '0;
      else if (!db_r)
         hold_r <= '0;
      else if (hold_r != HOLD_LAST)
         hold_r <= hold_r + 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         db_prev_r   <= 1'b0;
         long_done_r <= 1'b0;
         brief_r     <= 1'b0;
         long_r      <= 1'b0;
      end
      else
      begin
         db_prev_r <= db_r;
         long_r    <= db_r && !long_done_r && (hold_r == HOLD_LAST);
         // brief only at release, and never for a press that already ran long
         brief_r   <= db_prev_r && !db_r && !long_done_r;
         if (db_r && hold_r == HOLD_LAST)
            long_done_r <= 1'b1;
         else if (!db_r && !db_prev_r)
            long_done_r <= 1'b0;
      end
   end

   assign pressed_out = db_r;
   assign brief_out   = brief_r;
   assign long_out    = long_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_brief_at_release: assert property (brief_out |-> !pressed_out && $past(pressed_out, 2))
      else $error("brief press reported while button still down");
   a_long_after_hold: assert property (long_out |-> $past(pressed_out) && $past(hold_r) == HOLD_LAST)
      else $error("long press reported before full hold");
   a_press_exclusive: assert property (brief_out |-> !long_out)
      else $error("press classified both brief and long");

endmodule // smsel_press

// ==== verilog/smsel_top.sv ====
// smsel_top: front-panel smart mode selector with mode indicators and display
// Overview of operation
// - after boot and indicators off, a five second hold enters selection state.
// - indicators alternate all three on with the choice code while selection is active.
// - entering selection presets the choice to leave unchanged.
// - each brief press in selection advances to the next option.
// - another five second hold leaves selection and stores the current choice.
// - exactly four choices: unchanged, defaults, PROFINET, Ethernet/IP.
// - indicator and display codes: duplex S1, speed S2, both S3, activity S4.
// - indicators show the mode in force and the mode about to take effect.
// - defaults set aging to 40 s; configured aging accepted only 10 to 825 s.
`timescale 1ns/1ps
module smsel_top #(
   parameter int DEB_CYC   = smsel_pkg::DEBOUNCE_CYC,
   parameter int HOLD_CYC  = smsel_pkg::HOLD_CYC,
   parameter int BLINK_CYC = smsel_pkg::BLINK_CYC
) (
   input  wire logic                   clk_in,
   input  wire logic                   rstn_in,
   input  wire logic                   button_in,
   input  wire logic                   boot_done_in,
   input  wire logic                   aging_wr_in,
   input  wire logic [9:0]             aging_val_in,
   output smsel_pkg::smsel_led_t       led_out,
   output smsel_pkg::smsel_disp_t      disp_out,
   output smsel_pkg::smsel_mode_t      mode_out,
   output logic [9:0]                  aging_out,
   output logic                        defaults_out,
   output logic                        select_out,
   output logic                        aging_err_out
);
   localparam int            BW         = $clog2(BLINK_CYC + 1);
   localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYC - 1);

   smsel_pkg::smsel_state_t  state_r;
   smsel_pkg::smsel_choice_t choice_r;
   smsel_pkg::smsel_mode_t   mode_r;
   smsel_pkg::smsel_led_t    led_r;
   smsel_pkg::smsel_led_t    led_nxt;
   smsel_pkg::smsel_disp_t   disp_r;
   smsel_pkg::smsel_disp_t   disp_nxt;
   logic [9:0]               aging_r;
   logic [BW-1:0]            blink_cnt_r;
   logic                     blink_on_r;
   logic                     defaults_r;
   logic                     aging_err_r;
   logic                     brief;
   logic                     long_hold;
   logic                     commit;
   logic                     aging_ok;

   smsel_press #(
      .DEB_CYC  (DEB_CYC),
      .HOLD_CYC (HOLD_CYC)
   ) u_press (
      .clk_in      (clk_in),
      .rstn_in     (rstn_in),
      .button_in   (button_in),
      .pressed_out (),
      .brief_out   (brief),
      .long_out    (long_hold)
   );

   assign commit = (state_r == smsel_pkg::ST_SELECT) && long_hold;

   // a hold during boot is discarded, not remembered for later
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         state_r <= smsel_pkg::ST_BOOT;
      else
         unique case (state_r)
            smsel_pkg::ST_BOOT:
               if (boot_done_in)
                  state_r <= smsel_pkg::ST_IDLE;
            smsel_pkg::ST_IDLE:
               if (long_hold)
                  state_r <= smsel_pkg::ST_SELECT;
            smsel_pkg::ST_SELECT:
               if (long_hold)
                  state_r <= smsel_pkg::ST_IDLE;
            default:
               state_r <= smsel_pkg::ST_BOOT;
         endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         choice_r <= smsel_pkg::CH_KEEP;
      else if (state_r == smsel_pkg::ST_IDLE && long_hold)
         choice_r <= smsel_pkg::CH_KEEP;
      else if (state_r == smsel_pkg::ST_SELECT && brief)
         choice_r <= smsel_pkg::choice_next(choice_r);
   end

   // the committed choice becomes the mode in force
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         mode_r     <= smsel_pkg::MODE_ETH;
         defaults_r <= 1'b0;
      end
      else
      begin
         defaults_r <= commit && (choice_r == smsel_pkg::CH_DEFAULTS);
         if (commit)
            unique case (choice_r)
               smsel_pkg::CH_KEEP:     mode_r <= mode_r;
               smsel_pkg::CH_DEFAULTS: mode_r <= smsel_pkg::MODE_ETH;
               smsel_pkg::CH_PROFINET: mode_r <= smsel_pkg::MODE_PROFINET;
               smsel_pkg::CH_ENIP:     mode_r <= smsel_pkg::MODE_ENIP;
               default:                mode_r <= mode_r;
            endcase
      end
   end

   assign aging_ok = (aging_val_in >= smsel_pkg::AGING_MIN) && (aging_val_in <= smsel_pkg::AGING_MAX);

   // restoring defaults wins over a write in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         aging_r     <= smsel_pkg::AGING_DEF;
         aging_err_r <= 1'b0;
      end
      else
      begin
         aging_err_r <= aging_wr_in && !aging_ok;
         if (commit && choice_r == smsel_pkg::CH_DEFAULTS)
            aging_r <= smsel_pkg::AGING_DEF;
         else if (aging_wr_in && aging_ok)
            aging_r <= aging_val_in;
      end
   end

   // flash timer restarts on entry so the first phase is always full length
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in || state_r != smsel_pkg::ST_SELECT)
      begin
         blink_cnt_r <= '0;
         blink_on_r  <= 1'b1;
      end
      else if (blink_cnt_r == BLINK_LAST)
      begin
         blink_cnt_r <= '0;
         blink_on_r  <= !blink_on_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + 1'b1;
   end

   // flash alternates all-on with the choice code, so the choice stays readable
   always_comb
   begin
      led_nxt  = smsel_pkg::LED_OFF;
      disp_nxt = {smsel_pkg::CHAR_BLANK, smsel_pkg::CHAR_BLANK};
      unique case (state_r)
         smsel_pkg::ST_BOOT:
            led_nxt = smsel_pkg::LED_ALL;
         smsel_pkg::ST_IDLE:
            unique case (mode_r)
               smsel_pkg::MODE_PROFINET: led_nxt = smsel_pkg::choice_led(smsel_pkg::CH_PROFINET);
               smsel_pkg::MODE_ENIP:     led_nxt = smsel_pkg::choice_led(smsel_pkg::CH_ENIP);
               default:                  led_nxt = smsel_pkg::LED_OFF;
            endcase
         smsel_pkg::ST_SELECT:
         begin
            led_nxt  = blink_on_r ? smsel_pkg::LED_ALL : smsel_pkg::choice_led(choice_r);
            disp_nxt = {smsel_pkg::CHAR_S, smsel_pkg::choice_char(choice_r)};
         end
         default:
            led_nxt = smsel_pkg::LED_OFF;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         led_r  <= smsel_pkg::LED_ALL;
         disp_r <= {smsel_pkg::CHAR_BLANK, smsel_pkg::CHAR_BLANK};
      end
      else
      begin
         led_r  <= led_nxt;
         disp_r <= disp_nxt;
      end
   end

   assign led_out       = led_r;
   assign disp_out      = disp_r;
   assign mode_out      = mode_r;
   assign aging_out     = aging_r;
   assign defaults_out  = defaults_r;
   assign select_out    = (state_r == smsel_pkg::ST_SELECT);
   assign aging_err_out = aging_err_r;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   a_boot_ignores_hold: assert property (state_r == smsel_pkg::ST_BOOT |=> state_r != smsel_pkg::ST_SELECT)
      else $error("selection entered before boot finished");
   a_entry_presets_keep: assert property (state_r == smsel_pkg::ST_IDLE && long_hold |=> select_out && choice_r == smsel_pkg::CH_KEEP)
      else $error("selection entry did not preset leave-unchanged");
   a_select_flashes: assert property (select_out && blink_on_r && $past(select_out) |=> led_out == smsel_pkg::LED_ALL)
      else $error("indicators not all lit in flash phase");
   a_brief_steps: assert property (select_out && brief && choice_r == smsel_pkg::CH_ENIP |=> choice_r == smsel_pkg::CH_KEEP)
      else $error("choice did not wrap to leave-unchanged");
   a_brief_advances: assert property (select_out && brief |=> choice_r == smsel_pkg::choice_next($past(choice_r)))
      else $error("brief press did not advance choice");
   a_choice_onehot: assert property ($onehot(choice_r))
      else $error("choice outside the four options");
   a_commit_stores: assert property (commit && choice_r == smsel_pkg::CH_PROFINET |=> !select_out && mode_out == smsel_pkg::MODE_PROFINET)
      else $error("committed choice not stored");
   a_led_choice_code: assert property (select_out && !blink_on_r |=> led_out == smsel_pkg::choice_led($past(choice_r)))
      else $error("indicator code does not match choice");
   a_disp_choice_code: assert property (select_out && choice_r == smsel_pkg::CH_ENIP |=> disp_out.right == 8'h34)
      else $error("display code does not match choice");
   a_idle_shows_mode: assert property (state_r == smsel_pkg::ST_IDLE && mode_r == smsel_pkg::MODE_ENIP |=> led_out == 3'h4)
      else $error("indicators do not show mode in force");
   a_defaults_aging: assert property (commit && choice_r == smsel_pkg::CH_DEFAULTS |=> aging_out == 10'h028 && defaults_out)
      else $error("defaults did not restore aging time");
   a_aging_range: assert property (aging_wr_in && !aging_ok && !commit |=> $stable(aging_out) && aging_err_out)
      else $error("out of range aging time accepted");

   c_enter_select: cover property (state_r == smsel_pkg::ST_IDLE && long_hold);
   c_step_wrap: cover property (select_out && brief && choice_r == smsel_pkg::CH_ENIP);
   c_commit_defaults: cover property (commit && choice_r == smsel_pkg::CH_DEFAULTS);
   c_commit_enip: cover property (commit && choice_r == smsel_pkg::CH_ENIP);

endmodule // smsel_top

// ==== verification/smsel_panel.sv ====
// smsel_panel: front-panel mode button model with contact chatter
`timescale 1ns/1ps
module smsel_panel (
   input  wire logic clk_in,
   input  wire logic press_in,
   output logic      button_out
);
   logic       held_r;
   logic [1:0] bounce_r;

   initial
   begin
      held_r = 1'b0;
      bounce_r = 2'h0;
      button_out = 1'b0;
   end

   // contacts chatter for three cycles on every change, shorter than the debounce window
   always @(negedge clk_in)
   begin
      if (press_in != held_r)
      begin
         held_r <= press_in;
         bounce_r <= 2'h3;
         button_out <= ~button_out;
      end
      else if (bounce_r != 2'h0)
      begin
         bounce_r <= bounce_r - 2'h1;
         button_out <= (bounce_r == 2'h1) ? held_r : ~button_out;
      end
   end
endmodule // smsel_panel

// ==== verification/smsel_top_tb.sv ====
// smsel_top_tb: self-checking bench of the smart mode selector
`timescale 1ns/1ps
module smsel_top_tb;
   localparam int DEB   = 4;
   localparam int HOLD  = 40;
   localparam int BLINK = 8;
   localparam int LONG  = DEB + HOLD + 12;

   logic                   clk_in;
   logic                   rstn_in;
   logic                   button_in;
   logic                   boot_done_in;
   logic                   aging_wr_in;
   logic [9:0]             aging_val_in;
   logic                   press;
   smsel_pkg::smsel_led_t  led_out;
   smsel_pkg::smsel_disp_t disp_out;
   smsel_pkg::smsel_mode_t mode_out;
   logic [9:0]             aging_out;
   logic                   defaults_out;
   logic                   select_out;
   logic                   aging_err_out;
   int                     error_cnt;
   int                     checked;
   int                     dflt_n;
   int                     err_n;

   smsel_top #(.DEB_CYC(DEB), .HOLD_CYC(HOLD), .BLINK_CYC(BLINK)) DUT (
      .clk_in(clk_in), .rstn_in(rstn_in), .button_in(button_in), .boot_done_in(boot_done_in),
      .aging_wr_in(aging_wr_in), .aging_val_in(aging_val_in), .led_out(led_out), .disp_out(disp_out),
      .mode_out(mode_out), .aging_out(aging_out), .defaults_out(defaults_out),
      .select_out(select_out), .aging_err_out(aging_err_out));

   smsel_panel panel (.clk_in(clk_in), .press_in(press), .button_out(button_in));

   always #25 clk_in = ~clk_in;

   // pulses last one cycle, so they are counted rather than sampled by the sequence
   always @(posedge clk_in)
   begin
      if (defaults_out === 1'b1)
         dflt_n++;
      if (aging_err_out === 1'b1)
         err_n++;
   end

   function automatic logic [2:0] exp_led(input int idx);
      case (idx)
         0: return 3'h1;
         1: return 3'h2;
         2: return 3'h3;
         default: return 3'h4;
      endcase
   endfunction

   function automatic logic [2:0] idle_led(input logic [2:0] m);
      return (m == 3'h1) ? 3'h0 : ((m == 3'h2) ? 3'h3 : 3'h4);
   endfunction

   task automatic test_done;
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic push(input int len);
      press <= 1'b1;
      cyc(len);
      press <= 1'b0;
      cyc(DEB + 8);
   endtask

   task automatic flash(input int idx);
      int on_n;
      int code_n;
      on_n = 0;
      code_n = 0;
      repeat (2 * BLINK + 2)
      begin
         @(negedge clk_in);
         if (led_out === 3'h7)
            on_n++;
         else
         begin
            code_n++;
            chk_val("led code", {13'h0, exp_led(idx)}, {13'h0, led_out});
         end
      end
      chk_val("flash phases", 16'h1, {15'h0, (on_n > 0 && code_n > 0)});
   endtask

   task automatic aging_wr(input logic [9:0] v, inout logic [9:0] age_e);
      int e0;
      e0 = err_n;
      aging_wr_in = 1'b1;
      aging_val_in = v;
      cyc(1);
      aging_wr_in = 1'b0;
      cyc(2);
      if (v >= 10'h00a && v <= 10'h339)
         age_e = v;
      chk_val("aging", {6'h0, age_e}, {6'h0, aging_out});
      chk_val("aging refusals", 16'((v < 10'h00a || v > 10'h339) ? 1 : 0), 16'(err_n - e0));
   endtask

   initial
   begin
      cyc(30000);
      error_cnt++;
      test_done();
   end

   initial
   begin
      int t;
      int steps;
      int d0;
      logic [2:0] mode_e;
      logic [9:0] age_e;
      logic [9:0] corner [4];
      clk_in = 1'b0;
      rstn_in = 1'b0;
      boot_done_in = 1'b0;
      aging_wr_in = 1'b0;
      aging_val_in = 10'h000;
      press = 1'b0;
      error_cnt = 0;
      checked = 0;
      dflt_n = 0;
      err_n = 0;
      mode_e = 3'h1;
      age_e = 10'h028;
      corner = '{10'h009, 10'h00a, 10'h339, 10'h33a};
      void'($urandom(34));
      cyc(2);
      rstn_in = 1'b1;
      chk_val("reset aging", 16'h0028, {6'h0, aging_out});
      chk_val("reset select", 16'h0, {15'h0, select_out});
      push(LONG);
      chk_val("hold in boot", 16'h0, {15'h0, select_out});
      boot_done_in = 1'b1;
      cyc(3);
      chk_val("idle leds", 16'h0, {13'h0, led_out});
      push(DEB + 8);
      chk_val("brief in idle", 16'h0, {15'h0, select_out});
      for (int i = 0; i < 24; i++)
         aging_wr(i < 4 ? corner[i] : 10'($urandom % 1024), age_e);
      for (int n = 0; n < 9; n++)
      begin
         t = (n < 4) ? ((n * 2 + 2) % 5) % 4 : int'($urandom % 4);
         if (t == 1)
            aging_wr(10'h12c, age_e);
         push(LONG);
         chk_val("enter select", 16'h1, {15'h0, select_out});
         chk_val("preset choice", 16'h5331, disp_out);
         flash(0);
         steps = (t == 0) ? 4 : t;
         for (int k = 1; k <= steps; k++)
         begin
            // the long brief press sits just under the hold time
            push((k % 2 == 1) ? DEB + 8 : HOLD - 8);
            chk_val("choice display", {8'h53, 8'(8'h31 + k % 4)}, disp_out);
            flash(k % 4);
         end
         d0 = dflt_n;
         push(LONG);
         mode_e = (t == 1) ? 3'h1 : ((t == 2) ? 3'h2 : ((t == 3) ? 3'h4 : mode_e));
         if (t == 1)
            age_e = 10'h028;
         chk_val("exit select", 16'h0, {15'h0, select_out});
         chk_val("mode stored", {13'h0, mode_e}, {13'h0, mode_out});
         chk_val("idle leds", {13'h0, idle_led(mode_e)}, {13'h0, led_out});
         chk_val("idle display", 16'h2020, disp_out);
         chk_val("defaults pulse", 16'((t == 1) ? 1 : 0), 16'(dflt_n - d0));
         chk_val("aging after exit", {6'h0, age_e}, {6'h0, aging_out});
      end
      test_done();
   end
endmodule // smsel_top_tb
